// file: hdl/iosc_ctrl.sv
// internal oscillator block control top: registers, oscillators, multiplier, pins
`timescale 1ns/1ps
module iosc_ctrl
    import iosc_pkg::*;
(
    input  wire logic       clk_sys,              // system clock, 40 MHz
    input  wire logic       rst,                  // async reset, high
    input  wire logic [1:0] reg_addr,             // register index
    input  wire logic [7:0] reg_wdata,            // write data
    input  wire logic       reg_wr,               // write strobe
    input  wire logic       reg_rd,               // read strobe
    output logic      [7:0] reg_rdata,            // read data, cycle after strobe
    input  wire logic [3:0] primary_osc_cfg,      // primary oscillator configuration
    input  wire logic       pwrup_timer_en,       // power-up timer enabled
    input  wire logic       fail_safe_mon_en,     // fail-safe clock monitor enabled
    input  wire logic       watchdog_en,          // watchdog enabled
    input  wire logic       two_speed_en,         // two-speed start-up enabled
    input  wire logic       wake_two_speed,       // pulse: two-speed wake begins
    output logic            fast_internal_osc_en, // fast oscillator running
    output logic            slow_rc_osc_en,       // slow oscillator running
    output logic            fast_osc_tick,        // one pulse per fast cycle
    output logic            slow_osc_tick,        // one pulse per slow cycle
    output logic            dev_clk_tick,         // one pulse per device clock
    output logic            pll_active,           // 4x multiplier inserted
    output logic            exec_hold,            // instruction execution held
    output logic      [2:0] dev_freq_sel,         // select now in effect
    input  wire logic [1:0] port_a_out,           // port A bits 7:6 output data
    input  wire logic [1:0] port_a_oe,            // port A bits 7:6 drive enable
    output logic      [1:0] port_a_in,            // port A bits 7:6 pin levels
    input  wire logic       osc_input_pin_i,      // input pin level
    output logic            osc_input_pin_o,      // input pin drive value
    output logic            osc_input_pin_oe,     // input pin drive enable
    input  wire logic       osc_output_pin_i,     // output pin level
    output logic            osc_output_pin_o,     // output pin drive value
    output logic            osc_output_pin_oe     // output pin drive enable
);

    iosc_clk_if clk_bus ();

    // register state
    logic            low_freq_source_sel_reg;
    logic            pll_multiplier_en_reg;
    logic      [4:0] freq_trim_reg;
    logic      [2:0] internal_freq_sel_reg;
    logic      [7:0] rdata_reg;

    // oscillator state
    logic     [15:0] acc_reg;
    logic     [15:0] inc_reg;
    logic     [15:0] inc_target;
    logic     [16:0] acc_sum;
    logic      [3:0] slew_cnt_reg;
    logic     [10:0] slow_cnt_reg;
    logic            fast_tick_reg;
    logic            slow_tick_reg;

    // multiplier state
    iosc_pll_e       pll_state_reg;
    iosc_pll_e       pll_state_next;
    logic      [7:0] pll_cnt_reg;
    logic            hold_reg;

    // pin state
    logic      [1:0] clkout_div_reg;
    logic            clkout_reg;
    logic      [1:0] pin_meta_reg;
    logic      [1:0] pin_sync_reg;

    // decoded conditions
    logic            wr_tuning;
    logic            wr_control;
    logic            mode_clkout;
    logic            mode_all_io;
    logic            pll_avail;
    logic            sel_31k;
    logic            need_fast_req;
    logic            need_fast_act;
    logic            slow_forced;
    logic      [7:0] tuning_view;
    logic      [7:0] control_view;
    logic      [7:0] status_view;

    // write strobes per register
    always_comb
    begin
        wr_tuning  = 1'b0;
        wr_control = 1'b0;
        if (reg_wr && (reg_addr == IOSC_ADDR_TUNING))
            wr_tuning = 1'b1;
        else if (reg_wr && (reg_addr == IOSC_ADDR_CONTROL))
            wr_control = 1'b1;
    end

    // pin modes from the primary configuration
    assign mode_clkout = (primary_osc_cfg == IOSC_CFG_CLKOUT);
    assign mode_all_io = (primary_osc_cfg == IOSC_CFG_ALL_IO);

    // multiplier availability: internal mode and 4 or 8 MHz
    assign pll_avail = (mode_clkout || mode_all_io)
                    && ((internal_freq_sel_reg == IOSC_SEL_8M)
                     || (internal_freq_sel_reg == IOSC_SEL_4M));

    // tuning register: source select and trim, bit 5 absent
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            low_freq_source_sel_reg <= IOSC_TUNING_RESET[IOSC_TUN_SRC_BIT];
            freq_trim_reg           <= IOSC_TUNING_RESET[IOSC_TUN_TRIM_MSB:0];
        end
        else if (wr_tuning)
        begin
            low_freq_source_sel_reg <= reg_wdata[IOSC_TUN_SRC_BIT];
            freq_trim_reg           <= reg_wdata[IOSC_TUN_TRIM_MSB:0];
        end
    end

    // multiplier enable: software only, held clear when unavailable
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            pll_multiplier_en_reg <= IOSC_TUNING_RESET[IOSC_TUN_PLL_BIT];
        else if (!pll_avail)
            pll_multiplier_en_reg <= 1'b0;
        else if (wr_tuning)
            pll_multiplier_en_reg <= reg_wdata[IOSC_TUN_PLL_BIT];
    end

    // frequency select, 1 MHz after reset
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            internal_freq_sel_reg <= IOSC_SEL_RESET;
        else if (wr_control)
            internal_freq_sel_reg <= reg_wdata[IOSC_CTL_SEL_LSB +: 3];
    end

    // register views, unused bits zero
    assign tuning_view  = {low_freq_source_sel_reg, pll_multiplier_en_reg,
                           1'b0, freq_trim_reg};
    assign control_view = {1'b0, internal_freq_sel_reg, 4'h0};
    assign status_view  = {1'b0, mode_all_io, mode_clkout, exec_hold,
                           (pll_state_reg == IOSC_PLL_RUNNING), pll_active,
                           slow_rc_osc_en, fast_internal_osc_en};

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            rdata_reg <= 8'h00;
        else if (reg_rd && (reg_addr == IOSC_ADDR_TUNING))
            rdata_reg <= tuning_view;
        else if (reg_rd && (reg_addr == IOSC_ADDR_CONTROL))
            rdata_reg <= control_view;
        else if (reg_rd && (reg_addr == IOSC_ADDR_STATUS))
            rdata_reg <= status_view;
        else
            rdata_reg <= 8'h00;
    end

    assign reg_rdata = rdata_reg;

    // oscillator enables from requested and active selections
    assign sel_31k       = (internal_freq_sel_reg == IOSC_SEL_31K);
    assign need_fast_req = !sel_31k || low_freq_source_sel_reg;
    assign need_fast_act = !clk_bus.act_slow;
    assign slow_forced   = pwrup_timer_en || fail_safe_mon_en
                        || watchdog_en || two_speed_en;

    // fast oscillator stays up until a switch away has landed
    assign fast_internal_osc_en = need_fast_req || need_fast_act;
    assign slow_rc_osc_en       = slow_forced || clk_bus.act_slow
                               || (sel_31k && !low_freq_source_sel_reg);

    // trim target: centre increment plus signed trim step
    assign inc_target = IOSC_NOM_INC
                      + {{(11 - IOSC_TRIM_SHIFT){freq_trim_reg[4]}},
                         freq_trim_reg, {IOSC_TRIM_SHIFT{1'b0}}};

    // increment slews one step per interval toward the target
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            inc_reg      <= IOSC_NOM_INC;
            slew_cnt_reg <= 4'h0;
        end
        else if (slew_cnt_reg != IOSC_SLEW_LAST)
            slew_cnt_reg <= slew_cnt_reg + 4'h1;
        else
        begin
            slew_cnt_reg <= 4'h0;
            if ($signed(inc_reg) < $signed(inc_target))
                inc_reg <= inc_reg + 16'h0001;
            else if ($signed(inc_reg) > $signed(inc_target))
                inc_reg <= inc_reg - 16'h0001;
        end
    end

    // fast oscillator: phase accumulator carry is one cycle
    assign acc_sum = {1'b0, acc_reg} + {1'b0, inc_reg};

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            acc_reg       <= 16'h0000;
            fast_tick_reg <= 1'b0;
        end
        else if (fast_internal_osc_en)
        begin
            acc_reg       <= acc_sum[15:0];
            fast_tick_reg <= acc_sum[16];
        end
        else
            fast_tick_reg <= 1'b0;
    end

    // slow oscillator: fixed divider, never trimmed
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            slow_cnt_reg  <= 11'h000;
            slow_tick_reg <= 1'b0;
        end
        else if (!slow_rc_osc_en)
        begin
            slow_cnt_reg  <= 11'h000;
            slow_tick_reg <= 1'b0;
        end
        else if (slow_cnt_reg == IOSC_SLOW_LAST)
        begin
            slow_cnt_reg  <= 11'h000;
            slow_tick_reg <= 1'b1;
        end
        else
        begin
            slow_cnt_reg  <= slow_cnt_reg + 11'h001;
            slow_tick_reg <= 1'b0;
        end
    end

    // tick bundle to the postscaler
    assign clk_bus.fast_tick    = fast_tick_reg;
    assign clk_bus.slow_tick    = slow_tick_reg;
    assign clk_bus.req_sel      = internal_freq_sel_reg;
    assign clk_bus.req_fast_31k = low_freq_source_sel_reg;

    iosc_postscaler u_postscaler (
        .clk_sys (clk_sys),
        .rst     (rst),
        .bus     (clk_bus)
    );

    assign fast_osc_tick = fast_tick_reg;
    assign slow_osc_tick = slow_tick_reg;
    assign dev_clk_tick  = clk_bus.dev_tick;
    assign dev_freq_sel  = clk_bus.act_sel;

    // multiplier start sequence
    always_comb
    begin
        pll_state_next = pll_state_reg;
        case (pll_state_reg)
            IOSC_PLL_OFF:
                if (pll_multiplier_en_reg)
                    pll_state_next = IOSC_PLL_STARTING;
            IOSC_PLL_STARTING:
                if (!pll_multiplier_en_reg)
                    pll_state_next = IOSC_PLL_OFF;
                else if (pll_cnt_reg == IOSC_PLL_START_LAST)
                    pll_state_next = IOSC_PLL_RUNNING;
            IOSC_PLL_RUNNING:
                if (!pll_multiplier_en_reg)
                    pll_state_next = IOSC_PLL_OFF;
                else if (wake_two_speed)
                    pll_state_next = IOSC_PLL_STARTING;
            default:
                pll_state_next = IOSC_PLL_OFF;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            pll_state_reg <= IOSC_PLL_OFF;
        else
            pll_state_reg <= pll_state_next;
    end

    // start timer counts only while starting
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            pll_cnt_reg <= 8'h00;
        else if ((pll_state_reg != IOSC_PLL_STARTING) || (pll_state_next != IOSC_PLL_STARTING))
            pll_cnt_reg <= 8'h00;
        else
            pll_cnt_reg <= pll_cnt_reg + 8'h01;
    end

    assign pll_active = pll_multiplier_en_reg && pll_avail;

    // execution hold after a two-speed wake until the multiplier runs
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            hold_reg <= 1'b0;
        else if (wake_two_speed && pll_multiplier_en_reg)
            hold_reg <= 1'b1;
        else if ((pll_state_reg == IOSC_PLL_RUNNING) || !pll_multiplier_en_reg)
            hold_reg <= 1'b0;
    end

    assign exec_hold = hold_reg;

    // device clock over four for the clock-out pin
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            clkout_div_reg <= 2'h0;
            clkout_reg     <= 1'b0;
        end
        else if (clk_bus.dev_tick)
        begin
            clkout_div_reg <= clkout_div_reg + 2'h1;
            if (clkout_div_reg[0])
                clkout_reg <= ~clkout_reg;
        end
    end

    // pin level synchronisers, bit 1 input pin, bit 0 output pin
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pin_meta_reg <= 2'h0;
            pin_sync_reg <= 2'h0;
        end
        else
        begin
            pin_meta_reg <= {osc_input_pin_i, osc_output_pin_i};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // input pin is port A bit 7 in both internal modes
    always_comb
    begin
        osc_input_pin_o  = 1'b0;
        osc_input_pin_oe = 1'b0;
        if (mode_clkout || mode_all_io)
        begin
            osc_input_pin_o  = port_a_out[1];
            osc_input_pin_oe = port_a_oe[1];
        end
    end

    // output pin carries the clock or port A bit 6
    always_comb
    begin
        osc_output_pin_o  = 1'b0;
        osc_output_pin_oe = 1'b0;
        if (mode_clkout)
        begin
            osc_output_pin_o  = clkout_reg;
            osc_output_pin_oe = 1'b1;
        end
        else if (mode_all_io)
        begin
            osc_output_pin_o  = port_a_out[0];
            osc_output_pin_oe = port_a_oe[0];
        end
    end

    // port A sees the pins only when they are general I/O
    assign port_a_in[1] = (mode_clkout || mode_all_io) && pin_sync_reg[1];
    assign port_a_in[0] = mode_all_io && pin_sync_reg[0];

endmodule : iosc_ctrl

// file: include/iosc_pkg.sv
// constants, types and register map of the internal oscillator block control
// Summary of operation
// - fast oscillator gives 8 MHz direct and feeds a postscaler from 31 kHz to 4 MHz
// - fast oscillator runs for 125 kHz to 8 MHz, at lowest only if source select chooses it
// - slow oscillator runs when selected or forced by timers, clock monitor, two-speed start
// - frequency select chooses fast direct, slow direct or a postscaler tap
// - clock-out pin mode drives output pin with device clock over four; input pin is port A bit 7
// - all-I/O pin mode makes input pin port A bit 7 and output pin port A bit 6
// - trim is five-bit two's complement: 01111 maximum, 00000 centre, 10000 minimum
// - after a trim write the fast oscillator slews gradually; no done flag exists
// - slow oscillator ignores the trim; only the fast oscillator follows it
// - tuning bit 7 picks which oscillator supplies the 31 kHz option
// - tuning bit 6 inserts a 4x multiplier, giving 16 MHz or 32 MHz; software only; here the device clock ticks stay at 8 MHz or 4 MHz
// - multiplier usable only when primary configuration is 1001 or 1000
// - multiplier works only with frequency select 111 or 110
// - if conditions fail, multiplier is off, enable writes ignored, bit held clear
// - two-speed wake with multiplier enabled holds execution until multiplier has started
// - source select set: 31.25 kHz from postscaler; clear: slow oscillator, fast one off
// - frequency select 000 is the nominal 31 kHz setting where source select applies
// - any reset sets the frequency selection to 1 MHz
package iosc_pkg;

    // register indices on the plain port
    localparam logic [1:0] IOSC_ADDR_TUNING  = 2'h0;
    localparam logic [1:0] IOSC_ADDR_CONTROL = 2'h1;
    localparam logic [1:0] IOSC_ADDR_STATUS  = 2'h2;

    // tuning register fields
    localparam int IOSC_TUN_SRC_BIT  = 7;
    localparam int IOSC_TUN_PLL_BIT  = 6;
    localparam int IOSC_TUN_TRIM_MSB = 4;
    localparam logic [7:0] IOSC_TUNING_RESET = 8'h00;

    // control register frequency select field
    localparam int IOSC_CTL_SEL_LSB = 4;
    localparam logic [2:0] IOSC_SEL_8M    = 3'h7;
    localparam logic [2:0] IOSC_SEL_4M    = 3'h6;
    localparam logic [2:0] IOSC_SEL_31K   = 3'h0;
    localparam logic [2:0] IOSC_SEL_RESET = 3'h4;

    // primary oscillator configuration codes of the internal modes
    localparam logic [3:0] IOSC_CFG_CLKOUT = 4'h9;
    localparam logic [3:0] IOSC_CFG_ALL_IO = 4'h8;

    // clock rates
    localparam int IOSC_SYS_HZ  = 40000000;
    localparam int IOSC_FAST_HZ = 8000000;
    localparam int IOSC_SLOW_HZ = 31000;
    localparam int IOSC_SLOW_DIV = IOSC_SYS_HZ / IOSC_SLOW_HZ;
    localparam logic [10:0] IOSC_SLOW_LAST = 11'(IOSC_SLOW_DIV - 1);

    // fast oscillator phase accumulator
    localparam int IOSC_ACC_W = 16;
    localparam logic [15:0] IOSC_NOM_INC =
        16'((longint'(IOSC_FAST_HZ) * 65536) / IOSC_SYS_HZ);
    localparam int IOSC_TRIM_SHIFT = 6;
    localparam int IOSC_SLEW_US_X1000 = 200;
    localparam int IOSC_SLEW_CYC =
        (IOSC_SLEW_US_X1000 * (IOSC_SYS_HZ / 1000000) + 999) / 1000;
    localparam logic [3:0] IOSC_SLEW_LAST = 4'(IOSC_SLEW_CYC - 1);

    // multiplier start time
    localparam int IOSC_PLL_START_US = 2;
    localparam int IOSC_PLL_START_CYC = IOSC_PLL_START_US * (IOSC_SYS_HZ / 1000000);
    localparam logic [7:0] IOSC_PLL_START_LAST = 8'(IOSC_PLL_START_CYC - 1);

    // postscaler
    localparam logic [7:0] IOSC_PS_FULL = 8'hFF;

    // multiplier state, gray coded along off, starting, running
    typedef enum logic [1:0] {
        IOSC_PLL_OFF      = 2'b00,
        IOSC_PLL_STARTING = 2'b01,
        IOSC_PLL_RUNNING  = 2'b11
    } iosc_pll_e;

endpackage : iosc_pkg

// file: include/iosc_clk_if.sv
// clock tick bundle between the control top and the postscaler
`timescale 1ns/1ps
interface iosc_clk_if;
    logic       fast_tick;
    logic       slow_tick;
    logic [2:0] req_sel;
    logic       req_fast_31k;
    logic       dev_tick;
    logic       act_slow;
    logic [2:0] act_sel;
    logic       act_fast_31k;

    modport ctrl (
        output fast_tick, slow_tick, req_sel, req_fast_31k,
        input  dev_tick, act_slow, act_sel, act_fast_31k
    );
    modport scaler (
        input  fast_tick, slow_tick, req_sel, req_fast_31k,
        output dev_tick, act_slow, act_sel, act_fast_31k
    );
endinterface : iosc_clk_if

// file: hdl/iosc_postscaler.sv
// postscaler taps and device clock source selection, runt-free between fast taps
`timescale 1ns/1ps
module iosc_postscaler
    import iosc_pkg::*;
(
    input  wire logic clk_sys, // system clock
    input  wire logic rst,     // async reset, high
    iosc_clk_if.scaler bus     // tick bundle
);

    logic [7:0] ps_cnt_reg;
    logic [7:0] tap_mask;
    logic       tap_tick;
    logic       req_slow;
    logic       period_end;

    // divider count of fast ticks
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            ps_cnt_reg <= 8'h00;
        else if (bus.fast_tick)
            ps_cnt_reg <= ps_cnt_reg + 8'h01;
    end

    // tap mask from the active select, power-of-two division
    always_comb
    begin
        case (bus.act_sel)
            3'h7:    tap_mask = 8'h00;
            3'h6:    tap_mask = 8'h01;
            3'h5:    tap_mask = 8'h03;
            3'h4:    tap_mask = 8'h07;
            3'h3:    tap_mask = 8'h0F;
            3'h2:    tap_mask = 8'h1F;
            3'h1:    tap_mask = 8'h3F;
            default: tap_mask = 8'hFF; // 31.25 kHz tap
        endcase
    end

    assign tap_tick = bus.fast_tick && ((ps_cnt_reg & tap_mask) == tap_mask);
    assign req_slow = (bus.req_sel == IOSC_SEL_31K) && !bus.req_fast_31k;
    // selection only moves where every fast tap ends a full period, or at a slow tick while slow is active
    assign period_end = bus.act_slow ? bus.slow_tick
                                     : (bus.fast_tick && (ps_cnt_reg == IOSC_PS_FULL));

    // active selection latched at a period end
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            bus.act_sel      <= IOSC_SEL_RESET;
            bus.act_slow     <= 1'b0;
            bus.act_fast_31k <= 1'b0;
        end
        else if (period_end)
        begin
            bus.act_sel      <= bus.req_sel;
            bus.act_slow     <= req_slow;
            bus.act_fast_31k <= bus.req_fast_31k;
        end
    end

    // one device clock tick per selected period
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            bus.dev_tick <= 1'b0;
        else
            bus.dev_tick <= bus.act_slow ? bus.slow_tick : tap_tick;
    end

endmodule : iosc_postscaler

// file: tb/iosc_tree_model.sv
// far-side model: clock tree counting device ticks and clock-out pin edges
`timescale 1ns/1ps
module iosc_tree_model (
    input  wire logic        clk_sys,  // clock
    input  wire logic        rst,      // reset, high
    input  wire logic        dev_tick, // device clock tick
    input  wire logic        pin,      // clock-out pin level
    output logic      [15:0] ticks,    // ticks seen
    output logic      [15:0] edges     // pin changes seen
);
    logic last_reg;
    // count device clocks and pin changes
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
        begin
            {last_reg, ticks, edges} <= '0;
        end
        else
        begin
            last_reg <= pin;
            ticks    <= ticks + 16'(dev_tick);
            edges    <= edges + 16'(pin != last_reg);
        end
endmodule : iosc_tree_model

// file: tb/iosc_ctrl_chk.sv
// port checker of the oscillator block control
`timescale 1ns/1ps
module iosc_ctrl_chk (
    input wire logic       clk_sys, rst, reg_rd, wake_two_speed, // bus, wake
    input wire logic [1:0] reg_addr, port_a_out, port_a_oe,      // index, port
    input wire logic [7:0] reg_rdata,                            // read data
    input wire logic [3:0] primary_osc_cfg,                      // config
    input wire logic       pwrup_timer_en, fail_safe_mon_en,     // forcers
    input wire logic       watchdog_en, two_speed_en,            // forcers
    input wire logic       fast_internal_osc_en, slow_rc_osc_en, // osc on
    input wire logic       pll_active, exec_hold,                // multiplier
    input wire logic [2:0] dev_freq_sel,                         // select
    input wire logic       osc_output_pin_o, osc_output_pin_oe   // pin
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_pll_gate: assert property (
        reg_rd && reg_addr == 2'h0 && !(primary_osc_cfg inside {4'h9, 4'h8})
        && $past(!(primary_osc_cfg inside {4'h9, 4'h8})) |=> !reg_rdata[6])
        else $error("pll bit set outside internal modes");
    a_slow_forced: assert property (
        (pwrup_timer_en || fail_safe_mon_en || watchdog_en || two_speed_en)
        |-> slow_rc_osc_en) else $error("slow osc not forced");
    a_bit5_zero: assert property (
        reg_rd && reg_addr == 2'h0 |=> !reg_rdata[5]) else $error("bit5 set");
    a_hold_wake: assert property (
        wake_two_speed && pll_active |=> exec_hold) else $error("no hold");
    a_hold_ends: assert property (
        $rose(exec_hold) |-> ##[1:90] !exec_hold) else $error("hold stuck");
    a_fast_on: assert property (
        dev_freq_sel != 3'h0 |-> fast_internal_osc_en) else $error("fast off");
    a_clkout_drive: assert property (
        primary_osc_cfg == 4'h9 |-> osc_output_pin_oe) else $error("clkout oe");
    a_all_io: assert property (
        primary_osc_cfg == 4'h8 && port_a_oe[0] |-> osc_output_pin_oe
        && osc_output_pin_o == port_a_out[0]) else $error("io pin");
endmodule : iosc_ctrl_chk
bind iosc_ctrl iosc_ctrl_chk chk (.*);

// file: tb/tb.sv
// bench of the oscillator block control
`timescale 1ns/1ps
module tb;
    logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, wake_two_speed = 0;
    logic [1:0] reg_addr = 0, port_a_out = 0, port_a_oe = 0, port_a_in;
    logic [7:0] reg_wdata = 0, reg_rdata, d;
    logic [3:0] primary_osc_cfg = 0, frc = 0;
    logic [2:0] dev_freq_sel;
    logic [15:0] ticks, edges, t0, e0;
    logic fast_internal_osc_en, slow_rc_osc_en, fast_osc_tick, slow_osc_tick, dev_clk_tick;
    logic pll_active, exec_hold, osc_input_pin_o, osc_input_pin_oe, osc_output_pin_o;
    logic osc_output_pin_oe, osc_input_pin_i, osc_output_pin_i;
    int fail_count = 0, num_checks = 0;
    // pins pulled up when nobody drives
    assign osc_input_pin_i = osc_input_pin_oe ? osc_input_pin_o : 1'b1;
    assign osc_output_pin_i = osc_output_pin_oe ? osc_output_pin_o : 1'b1;
    iosc_ctrl uut (.pwrup_timer_en(frc[0]), .fail_safe_mon_en(frc[1]),
        .watchdog_en(frc[2]), .two_speed_en(frc[3]), .*);
    iosc_tree_model tree (.clk_sys(clk_sys), .rst(rst), .dev_tick(dev_clk_tick),
        .pin(osc_output_pin_o), .ticks(ticks), .edges(edges));
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk_sys) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge clk_sys) reg_wr <= 0;
    endtask : wr
    task automatic rd(input logic [1:0] a);
        @(posedge clk_sys) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk_sys) reg_rd <= 0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic wsel(input logic [2:0] s);
        int n;
        wr(2'h1, {1'b0, s, 4'h0});
        for (n = 0; dev_freq_sel !== s && n < 3000; n++) @(posedge clk_sys);
        #1 chk(dev_freq_sel, s);
    endtask : wsel
    task automatic t_regs;
        rd(2'h0); chk(d, 8'h00);
        rd(2'h1); chk(d, 8'h40);
        rd(2'h3); chk(d, 8'h00);
        wr(2'h0, 8'hFF); rd(2'h0); chk(d, 8'h9F);
        wr(2'h0, 8'h10); rd(2'h0); chk(d, 8'h10);
        $display("test regs done");
    endtask : t_regs
    task automatic t_pll;
        @(posedge clk_sys) primary_osc_cfg <= 4'h9;
        wsel(3'h7); wr(2'h0, 8'h40); rd(2'h0); chk(d, 8'h40);
        chk(pll_active, 1);
        @(posedge clk_sys) wake_two_speed <= 1;
        @(posedge clk_sys) wake_two_speed <= 0;
        #1 chk(exec_hold, 1);
        repeat (90) @(posedge clk_sys);
        #1 chk(exec_hold, 0);
        // wake while running restarts the multiplier for its 80-cycle start
        @(posedge clk_sys) wake_two_speed <= 1;
        @(posedge clk_sys) wake_two_speed <= 0;
        repeat (79) @(posedge clk_sys);
        #1 chk(exec_hold, 1);
        repeat (3) @(posedge clk_sys);
        #1 chk(exec_hold, 0);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_sys) frc <= 4'(1 << i);
            #1 chk(slow_rc_osc_en, 1);
        end
        @(posedge clk_sys) frc <= 0;
        t0 = ticks; e0 = edges; repeat (200) @(posedge clk_sys);
        // 5 us at 8 MHz is 40 ticks; margin for the trim still slewing back
        chk(8'((ticks - t0) inside {[38:40]}), 1);
        // one pin change per two device ticks, give or take the window ends
        chk(8'(2 * (edges - e0) + 3 >= ticks - t0
            && ticks - t0 + 3 >= 2 * (edges - e0)), 1);
        wsel(3'h6); wsel(3'h5); rd(2'h0); chk(d, 8'h00);
        $display("test pll done");
    endtask : t_pll
    task automatic t_pins;
        @(posedge clk_sys) {primary_osc_cfg, port_a_oe, port_a_out} <= {4'h8, 4'b1110};
        @(posedge clk_sys) #1;
        chk({osc_input_pin_oe, osc_input_pin_o, osc_output_pin_oe, osc_output_pin_o},
            4'b1110);
        repeat (3) @(posedge clk_sys); #1 chk(port_a_in, 2'b10);
        // released pins float to their pull-ups
        @(posedge clk_sys) port_a_oe <= 2'b00;
        repeat (3) @(posedge clk_sys); #1 chk(port_a_in, 2'b11);
        $display("test pins done");
    endtask : t_pins
    task automatic t_slow;
        wr(2'h0, 8'h0F); wsel(3'h0); chk(fast_internal_osc_en, 0);
        chk(slow_rc_osc_en, 1);
        // slow period stays 1290 cycles whatever the trim holds
        t0 = ticks; repeat (1290) @(posedge clk_sys);
        #1 chk(8'(ticks - t0), 1);
        // source select set: fast oscillator feeds the lowest setting
        wr(2'h0, 8'h80); #1 chk(fast_internal_osc_en, 1);
        $display("test slow done");
    endtask : t_slow
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst <= 0;
        t_regs(); t_pll(); t_pins(); t_slow();
        summarize();
    end
    initial
    begin
        #500000 fail_count++;
        summarize();
    end
endmodule : tb
